// ---- core/block_ram_pkg.sv ----
package block_ram_pkg;

    // ==========================================================
    // geometry
    localparam int unsigned BITS_PER_BLOCK     = 9216;
    localparam int unsigned SELECT_WIDTH       = 3;
    localparam int unsigned DEFAULT_DATA_WIDTH = 18;
    localparam int unsigned MAX_DATA_WIDTH     = 36;

    // ==========================================================
    // configuration defaults
    localparam logic [2:0] DEFAULT_SELECT_MATCH = 3'h0;
    localparam logic       DEFAULT_GLOBAL_CLEAR = 1'h1;
    localparam logic       GLOBAL_CLEAR_ENABLED = 1'h1;
    localparam logic       GLOBAL_CLEAR_DISABLED = 1'h0;

    // ==========================================================
    // settings
    typedef enum logic {
        direct_output    = 1'b0,
        pipelined_output = 1'b1
    } output_pipeline_setting_t;

    typedef enum logic {
        clear_async = 1'b0,
        clear_sync  = 1'b1
    } clear_type_setting_t;

    typedef enum logic [1:0] {
        normal_mode          = 2'b00,
        new_word_passthrough = 2'b01,
        old_word_first       = 2'b10
    } read_during_write_setting_t;

    // registered control bits of one port access
    typedef struct packed {
        logic                    issued;
        logic                    store;
        logic [SELECT_WIDTH-1:0] select;
    } access_ctrl_t;

    localparam access_ctrl_t CTRL_CLEARED = '{issued: 1'b0, store: 1'b0, select: 3'h0};

    // address width for each supported word width
    function automatic int unsigned addr_width_for(input int unsigned width);
        case (width)
            1:       return 13;
            2:       return 12;
            4:       return 11;
            9:       return 10;
            18:      return 9;
            36:      return 8;
            default: return 0;
        endcase
    endfunction

endpackage

// ---- core/block_ram_single_port.sv ----
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module block_ram_single_port #(
    parameter int unsigned                              DATA_WIDTH     = block_ram_pkg::DEFAULT_DATA_WIDTH,
    parameter block_ram_pkg::output_pipeline_setting_t   OUTPUT_SETTING = block_ram_pkg::direct_output,
    parameter block_ram_pkg::clear_type_setting_t        CLEAR_SETTING  = block_ram_pkg::clear_async,
    parameter logic [2:0]                               SELECT_MATCH   = block_ram_pkg::DEFAULT_SELECT_MATCH,
    parameter block_ram_pkg::read_during_write_setting_t RDW_SETTING    = block_ram_pkg::normal_mode,
    parameter logic                                     GLOBAL_CLEAR   = block_ram_pkg::DEFAULT_GLOBAL_CLEAR,
    parameter logic [DATA_WIDTH-1:0]                    PRELOAD_WORD   = '0
) (
    // clock and system reset
    input  wire logic                                                  clk,
    input  wire logic                                                  reset,
    // user port
    input  wire logic                                                  clock_qualify,
    input  wire logic                                                  store,
    input  wire logic                                                  register_clear,
    input  wire logic [block_ram_pkg::SELECT_WIDTH-1:0]               block_select,
    input  wire logic [block_ram_pkg::addr_width_for(DATA_WIDTH)-1:0] address,
    input  wire logic [DATA_WIDTH-1:0]                                write_word,
    // read data
    output logic      [DATA_WIDTH-1:0]                                read_word
);
    import block_ram_pkg::*;

    localparam int unsigned ADDR_WIDTH = addr_width_for(DATA_WIDTH);
    localparam int unsigned DEPTH      = 1 << ADDR_WIDTH;

    // ==========================================================
    // storage array, never touched by any clear
    logic [DATA_WIDTH-1:0] mem [DEPTH];

    // preload of the array contents at configuration time
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = PRELOAD_WORD;
        end
    end

    // ==========================================================
    // input and output registers
    logic [ADDR_WIDTH-1:0] addr_reg;
    logic [DATA_WIDTH-1:0] data_reg;
    access_ctrl_t          ctrl_reg;
    access_ctrl_t          ctrl_next;
    logic [DATA_WIDTH-1:0] core_out_reg;
    logic [DATA_WIDTH-1:0] core_out_next;
    logic [DATA_WIDTH-1:0] out_reg;

    // ==========================================================
    // clear decode
    wire clear_req   = register_clear | (GLOBAL_CLEAR & reset);
    // the asynchronous path is decoded from plain inputs; users must keep them glitch free
    wire async_clear = (CLEAR_SETTING == clear_async) & clear_req;
    wire sync_clear  = (CLEAR_SETTING == clear_sync) & clear_req;

    // ==========================================================
    // access decode
    wire                  capture    = clock_qualify;
    // a three bit select lets up to eight blocks stack in depth with no outside decode
    wire                  hit        = (ctrl_reg.select == SELECT_MATCH);
    wire                  array_fire = ctrl_reg.issued & hit & ~clear_req;
    wire                  write_fire = array_fire & ctrl_reg.store;
    wire                  read_fire  = array_fire & ~ctrl_reg.store;
    wire [DATA_WIDTH-1:0] stored     = mem[addr_reg];

    // control of the access just captured; issued lasts one cycle
    assign ctrl_next = '{issued: capture, store: store, select: block_select};

    // ==========================================================
    // read word of the array under each read during write setting
    always_comb begin
        core_out_next = core_out_reg;
        if (read_fire) begin
            core_out_next = stored;
        end else if (write_fire) begin
            unique case (RDW_SETTING)
                normal_mode:          core_out_next = core_out_reg;
                new_word_passthrough: core_out_next = data_reg;
                old_word_first:       core_out_next = stored;
                default:              core_out_next = core_out_reg;
            endcase
        end
    end

    // ==========================================================
    // input registers: address and word reach the array only through these
    always_ff @(posedge clk or posedge async_clear) begin
        if (async_clear) begin
            addr_reg <= '0;
            data_reg <= '0;
            ctrl_reg <= CTRL_CLEARED;
        end else if (sync_clear) begin
            addr_reg <= '0;
            data_reg <= '0;
            ctrl_reg <= CTRL_CLEARED;
        end else begin
            ctrl_reg <= capture ? ctrl_next : CTRL_CLEARED;
            if (capture) begin
                addr_reg <= address;
                data_reg <= write_word;
            end
        end
    end

    // array sense register, updated by selected reads and, outside normal_mode, by selected writes
    always_ff @(posedge clk or posedge async_clear) begin
        if (async_clear) begin
            core_out_reg <= '0;
        end else if (sync_clear) begin
            core_out_reg <= '0;
        end else begin
            core_out_reg <= core_out_next;
        end
    end

    // optional output pipeline register, moves only while qualified
    always_ff @(posedge clk or posedge async_clear) begin
        if (async_clear) begin
            out_reg <= '0;
        end else if (sync_clear) begin
            out_reg <= '0;
        end else if (clock_qualify) begin
            out_reg <= core_out_reg;
        end
    end

    // array write; a clear in the same cycle suppresses the write
    always_ff @(posedge clk) begin
        if (write_fire) begin
            mem[addr_reg] <= data_reg;
        end
    end

    // ==========================================================
    // output selection
    assign read_word = (OUTPUT_SETTING == pipelined_output) ? out_reg : core_out_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (clear_req);

    // helper copies for multi cycle checks
    logic [ADDR_WIDTH-1:0] probe_addr;
    assign probe_addr = addr_reg;

    sequence write_cycle;
        write_fire;
    endsequence

    sequence read_cycle;
        read_fire;
    endsequence

    sequence qualified_capture;
        capture && !clear_req;
    endsequence

    chk_input_capture: assert property (
        qualified_capture |=> (addr_reg == $past(address)) && (data_reg == $past(write_word))
    ) else $error("input registers missed a qualified capture");

    chk_unqualified_hold: assert property (
        !capture |=> $stable(addr_reg) && $stable(data_reg) && !ctrl_reg.issued
    ) else $error("input registers moved without clock qualify");

    chk_access_timing: assert property (
        qualified_capture ##1 (hit && !clear_req) |-> array_fire
    ) else $error("qualified access did not reach the array next cycle");

    chk_write_stores: assert property (
        write_cycle |=> mem[$past(probe_addr)] == $past(data_reg)
    ) else $error("write word not stored at registered address");

    chk_select_gate: assert property (
        (ctrl_reg.issued && ctrl_reg.store && !hit) |=> mem[$past(probe_addr)] == $past(mem[probe_addr])
    ) else $error("unselected block changed its array");

    chk_clear_regs: assert property (
        disable iff (1'b0) clear_req |=> (addr_reg == '0) && (read_word == '0) && !ctrl_reg.issued
    ) else $error("register clear left a register set");

    chk_clear_keeps_array: assert property (
        disable iff (1'b0) (clear_req && ctrl_reg.issued) |=> mem[$past(probe_addr)] == $past(mem[probe_addr])
    ) else $error("register clear changed the array");

    chk_read_data: assert property (
        read_cycle |=> core_out_reg == $past(stored)
    ) else $error("read word does not match stored word");

    property rdw_on_write;
        write_cycle |=> core_out_reg == ((RDW_SETTING == new_word_passthrough) ? $past(data_reg) :
                                         (RDW_SETTING == old_word_first) ? $past(stored) :
                                         $past(core_out_reg));
    endproperty

    chk_rdw_output: assert property (rdw_on_write)
        else $error("read word wrong during a write");

    chk_output_path: assert property (
        if (OUTPUT_SETTING == pipelined_output) (clock_qualify |=> read_word == $past(core_out_reg))
        else (read_word == core_out_reg)
    ) else $error("read word took the wrong output path");

    chk_block_size: assert property (
        (ADDR_WIDTH >= 8) && (ADDR_WIDTH <= 13) && (DEPTH * DATA_WIDTH <= BITS_PER_BLOCK)
    ) else $error("word width not a supported shape");

endmodule

`default_nettype wire

// ---- testbench/block_ram_user_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// user logic that drives the single memory port
module block_ram_user_model (
    // clock
    input  wire logic                                 clk,
    // memory port
    output logic                                      clock_qualify,
    output logic                                      store,
    output logic                                      register_clear,
    output logic [block_ram_pkg::SELECT_WIDTH-1:0]    block_select,
    output logic [8:0]                                address,
    output logic [block_ram_pkg::DEFAULT_DATA_WIDTH-1:0] write_word
);
    import block_ram_pkg::*;

    // idle port at time zero
    initial begin
        clock_qualify  = 1'b0;
        store          = 1'b0;
        register_clear = 1'b0;
        block_select   = 3'h0;
        address        = 9'h0;
        write_word     = 18'h0;
    end

    // one access, changed right after an edge and held for the capture edge
    task automatic drive(input logic q, input logic st, input logic [2:0] sel,
                         input logic [8:0] a, input logic [17:0] d);
        @(posedge clk);
        clock_qualify <= q;
        store         <= st;
        block_select  <= sel;
        address       <= a;
        write_word    <= d;
    endtask

    // released fields flip so a stale value can never pass for a live one
    task automatic rest();
        @(posedge clk);
        clock_qualify <= 1'b0;
        store         <= ~store;
        block_select  <= ~block_select;
        address       <= ~address;
        write_word    <= ~write_word;
    endtask

    // one-cycle register clear
    task automatic clear_pulse();
        @(posedge clk);
        register_clear <= 1'b1;
        @(posedge clk);
        register_clear <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ---- testbench/block_ram_single_port_test.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// three read-during-write flavours share one driven port
module block_ram_single_port_test;
    import block_ram_pkg::*;

    typedef struct packed {
        logic        st;
        logic [2:0]  sel;
        logic [8:0]  a;
        logic [17:0] d;
        logic [17:0] e0;
        logic [17:0] e1;
        logic [17:0] e2;
    } row_t;

    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        cq, st, rclr;
    logic [2:0]  sel;
    logic [8:0]  addr;
    logic [17:0] wd, rd_norm, rd_thru, rd_old, rd_pipe;
    logic [17:0] prev_e0 = 18'h0;
    int          fails = 0;
    int          samples_checked = 0;
    row_t        rows [8];

    // 4 ns period
    always #2 clk = ~clk;

    block_ram_user_model i_block_ram_user_model (.clk(clk), .clock_qualify(cq), .store(st),
        .register_clear(rclr), .block_select(sel), .address(addr), .write_word(wd));
    block_ram_single_port i_block_ram_single_port (.clk(clk), .reset(reset),
        .clock_qualify(cq), .store(st), .register_clear(rclr), .block_select(sel),
        .address(addr), .write_word(wd), .read_word(rd_norm));
    block_ram_single_port #(.RDW_SETTING(new_word_passthrough)) i_block_ram_single_port_thru (
        .clk(clk), .reset(reset), .clock_qualify(cq), .store(st), .register_clear(rclr),
        .block_select(sel), .address(addr), .write_word(wd), .read_word(rd_thru));
    block_ram_single_port #(.RDW_SETTING(old_word_first)) i_block_ram_single_port_old (
        .clk(clk), .reset(reset), .clock_qualify(cq), .store(st), .register_clear(rclr),
        .block_select(sel), .address(addr), .write_word(wd), .read_word(rd_old));
    // pipelined output with synchronous clear; its register moves on the next qualified edge
    block_ram_single_port #(.OUTPUT_SETTING(pipelined_output), .CLEAR_SETTING(clear_sync))
        i_block_ram_single_port_pipe (
        .clk(clk), .reset(reset), .clock_qualify(cq), .store(st), .register_clear(rclr),
        .block_select(sel), .address(addr), .write_word(wd), .read_word(rd_pipe));

    task automatic wrap_up();
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check_word(input string name, input logic [17:0] exp, input logic [17:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic check_all(input logic [17:0] e0, input logic [17:0] e1, input logic [17:0] e2);
        check_word("normal read_word", e0, rd_norm);
        check_word("passthrough read_word", e1, rd_thru);
        check_word("old_first read_word", e2, rd_old);
    endtask

    // release, then wait for the array edge after the capture edge
    task automatic finish_access();
        i_block_ram_user_model.rest();
        @(posedge clk);
        #1;
    endtask

    // watchdog sized well beyond the roughly 60 cycles of traffic
    initial begin
        #4000;
        fails++;
        wrap_up();
    end

    initial begin
        rows[0] = '{1'b1, 3'h0, 9'h005, 18'h2a5a5, 18'h0, 18'h2a5a5, 18'h0};
        rows[1] = '{1'b0, 3'h0, 9'h005, 18'h0, 18'h2a5a5, 18'h2a5a5, 18'h2a5a5};
        rows[2] = '{1'b1, 3'h0, 9'h005, 18'h15a5a, 18'h2a5a5, 18'h15a5a, 18'h2a5a5};
        rows[3] = '{1'b1, 3'h1, 9'h1ff, 18'h3ffff, 18'h2a5a5, 18'h15a5a, 18'h2a5a5};
        rows[4] = '{1'b0, 3'h0, 9'h1ff, 18'h0, 18'h0, 18'h0, 18'h0};
        rows[5] = '{1'b1, 3'h0, 9'h1ff, 18'h00001, 18'h0, 18'h00001, 18'h0};
        rows[6] = '{1'b0, 3'h0, 9'h005, 18'h0, 18'h15a5a, 18'h15a5a, 18'h15a5a};
        rows[7] = '{1'b0, 3'h3, 9'h1ff, 18'h0, 18'h15a5a, 18'h15a5a, 18'h15a5a};
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        check_all(18'h0, 18'h0, 18'h0);
        // ordinary traffic: writes, reads, select mismatches
        foreach (rows[i]) begin
            i_block_ram_user_model.drive(1'b1, rows[i].st, rows[i].sel, rows[i].a, rows[i].d);
            finish_access();
            check_all(rows[i].e0, rows[i].e1, rows[i].e2);
            check_word("pipelined read_word", prev_e0, rd_pipe);
            prev_e0 = rows[i].e0;
        end
        // unqualified write must leave no trace
        i_block_ram_user_model.drive(1'b0, 1'b1, 3'h0, 9'h005, 18'h00003);
        i_block_ram_user_model.drive(1'b1, 1'b0, 3'h0, 9'h005, 18'h0);
        finish_access();
        check_all(18'h15a5a, 18'h15a5a, 18'h15a5a);
        // clear empties the output but not the array
        i_block_ram_user_model.clear_pulse();
        #1;
        check_all(18'h0, 18'h0, 18'h0);
        check_word("pipelined read_word", 18'h0, rd_pipe);
        i_block_ram_user_model.drive(1'b1, 1'b0, 3'h0, 9'h1ff, 18'h0);
        finish_access();
        check_all(18'h00001, 18'h00001, 18'h00001);
        // write then read of the same word on consecutive edges
        i_block_ram_user_model.drive(1'b1, 1'b1, 3'h0, 9'h010, 18'h00111);
        i_block_ram_user_model.drive(1'b1, 1'b0, 3'h0, 9'h010, 18'h0);
        finish_access();
        check_all(18'h00111, 18'h00111, 18'h00111);
        wrap_up();
    end
endmodule

`default_nettype wire
